// ### core/sba_pkg.sv
// Shared constants and types for the system bus arbiter
package sba_pkg;

	// ------------------------------------------------------------
	// Processor cycle status codes, lines read as {s2, s1, s0}
	// ------------------------------------------------------------
	localparam logic [2:0] ST_INT_ACK = 3'h0;
	localparam logic [2:0] ST_IO_READ = 3'h1;
	localparam logic [2:0] ST_IO_WRITE = 3'h2;
	localparam logic [2:0] ST_HALT = 3'h3;
	localparam logic [2:0] ST_FETCH = 3'h4;
	localparam logic [2:0] ST_MEM_READ = 3'h5;
	localparam logic [2:0] ST_MEM_WRITE = 3'h6;
	localparam logic [2:0] ST_PASSIVE = 3'h7;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	localparam int SYNC_WIDTH = 5;
	localparam int SYNC_PRI = 0;
	localparam int SYNC_SHARED_BUS_REQUEST = 1;
	localparam int SYNC_BUSY = 2;
	localparam int SYNC_HOLD = 3;
	localparam int SYNC_EACH = 4;
	// Reset value of the filtered pins: all lines high; busy and request read idle
	localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 5'h1F;
	// Edges for which our own dropped request may still show on the sensed line
	localparam int OWN_REQ_LAG = 4;

	// ------------------------------------------------------------
	// Arbiter states, Gray along idle, wait, own, release
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SBA_IDLE = 2'h0,
		SBA_WAIT = 2'h1,
		SBA_OWN = 2'h3,
		SBA_RELEASE = 2'h2
	} sba_state_t;

endpackage

// ### core/sba_pin_if.sv
// Carrier between the arbiter and its pin synchroniser
interface sba_pin_if;
	logic [sba_pkg::SYNC_WIDTH-1:0] raw;
	logic [sba_pkg::SYNC_WIDTH-1:0] clean;

	modport sync (
		input raw,
		output clean
	);

	modport user (
		output raw,
		input clean
	);
endinterface

// ### core/sba_sync.sv
// Three-stage pin synchroniser with agreement filter
module sba_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in, filtered levels out
	sba_pin_if.sync pins
);

	logic [sba_pkg::SYNC_WIDTH-1:0] s1_q;
	logic [sba_pkg::SYNC_WIDTH-1:0] s2_q;
	logic [sba_pkg::SYNC_WIDTH-1:0] s3_q;
	logic [sba_pkg::SYNC_WIDTH-1:0] clean_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= sba_pkg::SYNC_RESET;
			s2_q <= sba_pkg::SYNC_RESET;
			s3_q <= sba_pkg::SYNC_RESET;
		end else begin
			s1_q <= pins.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A level counts only once stages two and three agree, per bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clean_q <= sba_pkg::SYNC_RESET;
		end else begin
			clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
		end
	end

	assign pins.clean = clean_q;

endmodule

// ### core/sba_arbiter.sv
// System bus arbiter for one processor board
module sba_arbiter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Processor side, same clock
	input wire logic [2:0] proc_cycle_status,
	input wire logic proc_hold_n,
	input wire logic local_or_system_select,
	// Board straps and controls
	input wire logic local_ports_strap,
	input wire logic resident_strap,
	input wire logic common_req_hold_in,
	input wire logic release_each_access_in,
	// Shared bus side
	input wire logic priority_grant_in,
	input wire logic shared_bus_request_in,
	input wire logic bus_busy_n_in,
	output logic shared_bus_request_out,
	output logic shared_bus_request_oe,
	output logic bus_busy_n_out,
	output logic bus_busy_n_oe,
	output logic priority_req_out,
	// Towards the bus command controller
	output logic addr_enable_n,
	output logic bus_owner
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	sba_pin_if pins ();

	assign pins.raw[sba_pkg::SYNC_PRI] = priority_grant_in;
	assign pins.raw[sba_pkg::SYNC_SHARED_BUS_REQUEST] = shared_bus_request_in;
	assign pins.raw[sba_pkg::SYNC_BUSY] = bus_busy_n_in;
	assign pins.raw[sba_pkg::SYNC_HOLD] = common_req_hold_in;
	assign pins.raw[sba_pkg::SYNC_EACH] = release_each_access_in;

	sba_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pins(pins)
	);

	logic higher_req;
	logic other_req;
	logic bus_free;
	logic shared_bus_request_hold_off;
	logic each_release;
	logic [sba_pkg::OWN_REQ_LAG-1:0] own_req_hist_q;

	// Our own pull on the shared request line takes the synchroniser's lag to
	// leave the sensed level; without this mask a fresh owner would see its
	// own request and surrender at once. A real request is only delayed.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			own_req_hist_q <= '0;
		end else begin
			own_req_hist_q <= {own_req_hist_q[sba_pkg::OWN_REQ_LAG-2:0], shared_bus_request_oe};
		end
	end

	assign higher_req = pins.clean[sba_pkg::SYNC_PRI];
	assign other_req = !pins.clean[sba_pkg::SYNC_SHARED_BUS_REQUEST] && !(|own_req_hist_q);
	assign bus_free = pins.clean[sba_pkg::SYNC_BUSY];
	assign shared_bus_request_hold_off = pins.clean[sba_pkg::SYNC_HOLD];
	assign each_release = pins.clean[sba_pkg::SYNC_EACH];

	// ------------------------------------------------------------
	// Configuration straps
	// ------------------------------------------------------------
	// Straps are captured on the first edge after reset release, not by the
	// reset itself, so a strap driven late by board logic is still honoured.
	logic straps_taken_q;
	logic ports_mode_q;
	logic resident_mode_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			straps_taken_q <= 1'b0;
			ports_mode_q <= 1'b0;
			resident_mode_q <= 1'b0;
		end else if (!straps_taken_q) begin
			straps_taken_q <= 1'b1;
			ports_mode_q <= !local_ports_strap;
			resident_mode_q <= resident_strap;
		end
	end

	// ------------------------------------------------------------
	// Status decode
	// ------------------------------------------------------------
	function automatic logic is_io(input logic [2:0] st);
		is_io = (st == sba_pkg::ST_INT_ACK) || (st == sba_pkg::ST_IO_READ) ||
			(st == sba_pkg::ST_IO_WRITE);
	endfunction

	function automatic logic is_mem(input logic [2:0] st);
		is_mem = (st == sba_pkg::ST_FETCH) || (st == sba_pkg::ST_MEM_READ) ||
			(st == sba_pkg::ST_MEM_WRITE);
	endfunction

	logic io_cyc;
	logic mem_cyc;
	logic access_cyc;
	logic halt_cyc;
	logic idle_cyc;
	logic sel_system;
	logic prev_access_q;
	logic access_end;

	assign io_cyc = is_io(proc_cycle_status);
	assign mem_cyc = is_mem(proc_cycle_status);
	assign access_cyc = io_cyc || mem_cyc;
	assign halt_cyc = (proc_cycle_status == sba_pkg::ST_HALT);
	assign idle_cyc = (proc_cycle_status == sba_pkg::ST_PASSIVE);
	assign sel_system = local_or_system_select;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_access_q <= 1'b0;
		end else begin
			prev_access_q <= access_cyc;
		end
	end

	assign access_end = prev_access_q && !access_cyc;

	// ------------------------------------------------------------
	// Request and surrender terms per configuration
	// ------------------------------------------------------------
	logic need_bus;
	logic shared_bus_request_term;
	logic surrender;

	always_comb begin
		need_bus = 1'b0;
		shared_bus_request_term = 1'b0;
		case ({ports_mode_q, resident_mode_q})
			2'h0: begin
				need_bus = access_cyc;
				shared_bus_request_term = idle_cyc;
			end
			2'h1: begin
				need_bus = access_cyc && sel_system;
				shared_bus_request_term = !sel_system || idle_cyc;
			end
			2'h2: begin
				need_bus = mem_cyc;
				shared_bus_request_term = io_cyc || idle_cyc;
			end
			2'h3: begin
				need_bus = mem_cyc && sel_system;
				shared_bus_request_term = io_cyc || !sel_system;
			end
			default: begin
				need_bus = 1'b0;
				shared_bus_request_term = 1'b0;
			end
		endcase
	end

	// Surrender is never taken in the middle of a cycle that needs the bus
	always_comb begin
		surrender = halt_cyc || higher_req;
		if (shared_bus_request_hold_off && other_req && shared_bus_request_term) begin
			surrender = 1'b1;
		end
		if (each_release && access_end) begin
			surrender = 1'b1;
		end
		if (need_bus || !proc_hold_n) begin
			surrender = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Arbitration state
	// ------------------------------------------------------------
	sba_pkg::sba_state_t state_q;
	sba_pkg::sba_state_t state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			sba_pkg::SBA_IDLE: begin
				if (straps_taken_q && need_bus) begin
					state_d = sba_pkg::SBA_WAIT;
				end
			end
			sba_pkg::SBA_WAIT: begin
				// The busy line keeps us off while another board owns it
				if (!higher_req && bus_free) begin
					state_d = sba_pkg::SBA_OWN;
				end else if (!need_bus && proc_hold_n) begin
					state_d = sba_pkg::SBA_IDLE;
				end
			end
			sba_pkg::SBA_OWN: begin
				if (surrender) begin
					state_d = sba_pkg::SBA_RELEASE;
				end
			end
			sba_pkg::SBA_RELEASE: begin
				state_d = sba_pkg::SBA_IDLE;
			end
			default: begin
				state_d = sba_pkg::SBA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sba_pkg::SBA_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	logic owning_d;
	logic asking_d;

	assign owning_d = (state_d == sba_pkg::SBA_OWN);
	assign asking_d = (state_d == sba_pkg::SBA_WAIT) || owning_d;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_owner <= 1'b0;
			addr_enable_n <= 1'b1;
			bus_busy_n_oe <= 1'b0;
			bus_busy_n_out <= 1'b0;
		end else begin
			bus_owner <= owning_d;
			addr_enable_n <= !owning_d;
			bus_busy_n_oe <= owning_d;
			bus_busy_n_out <= 1'b0;
		end
	end

	// Shared request is pulled low only while waiting; an owner does not
	// need it, and pulling it would block surrender on other boards.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_bus_request_oe <= 1'b0;
			shared_bus_request_out <= 1'b0;
			priority_req_out <= 1'b0;
		end else begin
			shared_bus_request_oe <= (state_d == sba_pkg::SBA_WAIT);
			shared_bus_request_out <= 1'b0;
			priority_req_out <= asking_d;
		end
	end

endmodule

// ### dv/sba_properties.sv
// Pin-level assertions for the system bus arbiter
module sba_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Inputs watched
	input wire logic [2:0] proc_cycle_status,
	input wire logic proc_hold_n,
	input wire logic local_or_system_select,
	input wire logic local_ports_strap,
	input wire logic resident_strap,
	input wire logic priority_grant_in,
	input wire logic bus_busy_n_in,
	// Outputs watched
	input wire logic shared_bus_request_out,
	input wire logic shared_bus_request_oe,
	input wire logic bus_busy_n_out,
	input wire logic bus_busy_n_oe,
	input wire logic priority_req_out,
	input wire logic addr_enable_n,
	input wire logic bus_owner
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic up_q;
	logic acc;
	logic need;
	// Straps are only taken on the first edge, so decoding counts from the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) up_q <= 1'b0;
		else up_q <= 1'b1;
	end
	assign acc = proc_cycle_status != sba_pkg::ST_HALT && proc_cycle_status != sba_pkg::ST_PASSIVE;
	assign need = (local_ports_strap ? acc : acc && proc_cycle_status[2])
		&& (!resident_strap || local_or_system_select);

	a_owner_addr: assert property (bus_owner != addr_enable_n)
		else $error("owner flag and address enable disagree");
	a_owner_busy: assert property (bus_owner |-> bus_busy_n_oe && !bus_busy_n_out)
		else $error("owner does not pull the busy line");
	a_wait_alone: assert property (shared_bus_request_oe |-> !bus_owner && priority_req_out)
		else $error("shared request driven outside waiting");
	a_hold_keeps: assert property (bus_owner && !proc_hold_n |=> bus_owner)
		else $error("bus given up while hold low");
	a_release_gap: assert property ($fell(bus_owner) |-> !priority_req_out ##1 !bus_owner)
		else $error("release cycle malformed");
	a_need_asks: assert property (up_q && !priority_req_out && !$past(bus_owner) && need
		|=> priority_req_out) else $error("needed access raised no request");
	a_no_need_quiet: assert property (up_q && !priority_req_out && !$past(bus_owner)
		&& !need && proc_hold_n |=> !priority_req_out) else $error("request without need");
	a_blocked_no_win: assert property ((priority_grant_in || !bus_busy_n_in)[*8]
		|-> !$rose(bus_owner)) else $error("bus won while blocked");

	a_req_open_drain: assert property (shared_bus_request_oe |-> !shared_bus_request_out)
		else $error("shared request driven high");

	c_win: cover property ($rose(bus_owner));
	c_hold_own: cover property (bus_owner && !proc_hold_n);
	c_give_up: cover property ($fell(bus_owner));
	c_blocked: cover property (shared_bus_request_oe && !bus_busy_n_in);
endmodule

// ### dv/sba_bus_model.sv
// Other boards on the shared bus: busy and request as open-drain lines with pull-ups, grant passed straight through
module sba_bus_model (
	// Our drivers
	input wire logic req_oe,
	input wire logic busy_oe,
	// What the other boards do
	input wire logic other_busy,
	input wire logic other_req,
	input wire logic higher_req,
	// Lines as sensed
	output logic req_n,
	output logic busy_n,
	output logic grant
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released line floats back to the pull-up level
	assign busy_n = !(busy_oe || other_busy);
	assign req_n = !(req_oe || other_req);
	assign grant = higher_req;
endmodule

// ### dv/sba_arbiter_tb_top.sv
// Self-checking testbench for the system bus arbiter
module sba_arbiter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, lps, res, hold_n, sel, crq, each, o_busy, o_req, hi;
	logic [2:0] st;
	logic [6:0] ctl;
	logic grant, req_n, busy_n, req_oe, busy_oe, prq, aen_n, own;
	int bad_count = 0;
	int n_checks = 0;
	assign {hold_n, sel, crq, each, o_busy, o_req, hi} = ctl;

	sba_arbiter u_sba_arbiter (.clk, .rst_n, .proc_cycle_status(st), .proc_hold_n(hold_n),
		.local_or_system_select(sel), .local_ports_strap(lps), .resident_strap(res),
		.common_req_hold_in(crq), .release_each_access_in(each), .priority_grant_in(grant),
		.shared_bus_request_in(req_n), .bus_busy_n_in(busy_n), .shared_bus_request_out(),
		.shared_bus_request_oe(req_oe), .bus_busy_n_out(), .bus_busy_n_oe(busy_oe),
		.priority_req_out(prq), .addr_enable_n(aen_n), .bus_owner(own));
	sba_bus_model u_sba_bus_model (.req_oe, .busy_oe, .other_busy(o_busy),
		.other_req(o_req), .higher_req(hi), .req_n, .busy_n, .grant);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Drive status and controls on an edge, then look just after the n-th edge
	task automatic step(input logic [2:0] s, input logic [6:0] c, input int n);
		@(posedge clk);
		st <= s;
		ctl <= c;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cfg(input logic l, input logic r);
		@(posedge clk);
		rst_n <= 1'b0;
		lps <= l;
		res <= r;
		st <= sba_pkg::ST_PASSIVE;
		ctl <= 7'h70;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	function automatic logic need(input int c, input int s);
		logic acc;
		acc = s[2:0] != 3'h3 && s[2:0] != 3'h7;
		return acc && (!c[1] || s[2]) && (!c[0] || s[3]);
	endfunction
	task automatic give_verdict();
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		lps = 1'b1;
		res = 1'b0;
		st = sba_pkg::ST_PASSIVE;
		ctl = 7'h70;
		for (int c = 0; c < 4; c++) begin
			cfg(!c[1], c[0]);
			for (int s = 0; s < 16; s++) begin
				step(s[2:0], s[3] ? 7'h70 : 7'h50, 2);
				chk("request", need(c, s), prq);
				step(sba_pkg::ST_HALT, 7'h70, 8);
				chk("idle after halt", 1'b0, prq);
			end
		end
		cfg(1'b1, 1'b0);
		step(sba_pkg::ST_MEM_READ, 7'h70, 4);
		step(sba_pkg::ST_PASSIVE, 7'h70, 8);
		chk("owner kept after own request", 1'b1, own);
		cfg(1'b0, 1'b1);
		step(sba_pkg::ST_MEM_READ, 7'h70, 8);
		chk("owner", 1'b1, own);
		chk("address enable", 1'b0, aen_n);
		chk("busy drive", 1'b1, busy_oe);
		step(sba_pkg::ST_HALT, 7'h30, 10);
		chk("owner under hold", 1'b1, own);
		step(sba_pkg::ST_PASSIVE, 7'h70, 10);
		chk("owner after hold", 1'b1, own);
		step(sba_pkg::ST_PASSIVE, 7'h71, 8);
		chk("owner on higher request", 1'b0, own);
		chk("address enable released", 1'b1, aen_n);
		step(sba_pkg::ST_MEM_READ, 7'h71, 10);
		chk("owner while outranked", 1'b0, own);
		chk("waiting", 1'b1, req_oe);
		step(sba_pkg::ST_MEM_READ, 7'h74, 10);
		chk("owner while bus busy", 1'b0, own);
		step(sba_pkg::ST_MEM_READ, 7'h70, 8);
		chk("owner when free", 1'b1, own);
		step(sba_pkg::ST_MEM_READ, 7'h78, 6);
		step(sba_pkg::ST_PASSIVE, 7'h78, 8);
		chk("owner after single access", 1'b0, own);
		cfg(1'b1, 1'b1);
		step(sba_pkg::ST_MEM_READ, 7'h70, 8);
		step(sba_pkg::ST_PASSIVE, 7'h62, 10);
		chk("owner with request hold", 1'b1, own);
		step(sba_pkg::ST_PASSIVE, 7'h72, 8);
		chk("owner on shared request", 1'b0, own);
		give_verdict();
	end

	// Whole run is about 1,000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule

bind sba_arbiter sba_properties u_sba_properties (.clk, .rst_n, .proc_cycle_status,
	.proc_hold_n, .local_or_system_select, .local_ports_strap, .resident_strap,
	.priority_grant_in, .bus_busy_n_in, .shared_bus_request_out,
	.shared_bus_request_oe, .bus_busy_n_out,
	.bus_busy_n_oe, .priority_req_out, .addr_enable_n, .bus_owner);
